// *** hdl/psd_consts.svh ***
`ifndef PSD_CONSTS_SVH
`define PSD_CONSTS_SVH

// Strap ADC code: 12 bits, full scale 3.3 V, code = volts * 4096 / 3.3
`define PSD_CODE_W 12
`define PSD_TH_00 12'h0_097
`define PSD_TH_01 12'h0_1A3
`define PSD_TH_02 12'h0_2A8
`define PSD_TH_03 12'h0_3AA
`define PSD_TH_04 12'h0_4A9
`define PSD_TH_05 12'h0_5A3
`define PSD_TH_06 12'h0_6A0
`define PSD_TH_07 12'h0_7A2
`define PSD_TH_08 12'h0_8A6
`define PSD_TH_09 12'h0_9A7
`define PSD_TH_10 12'h0_AA4
`define PSD_TH_11 12'h0_BAC
`define PSD_TH_12 12'h0_CB3
`define PSD_TH_13 12'h0_DC4
`define PSD_TH_14 12'h0_EC6

// Register map (byte addresses, word aligned)
`define PSD_ADDR_W 4
`define PSD_REG_MODE 4'h0
`define PSD_REG_CTRL 4'h4
`define PSD_REG_STAT 4'h8

// Field positions in MODE register
`define PSD_F_BAND_LO 0
`define PSD_F_BAND_HI 3
`define PSD_F_ENDPT 4
`define PSD_F_AUTORS 5
`define PSD_F_TYPE2 6
`define PSD_F_CLASS 7
`define PSD_F_MARK 8
`define PSD_F_PWR_LO 9
`define PSD_F_PWR_HI 10
`define PSD_F_VALID 11

// Timing at 100 MHz clock
`define PSD_CLK_MHZ 100
`define PSD_DET_ENDPT_MS 400
`define PSD_DET_MIDSP_MS 2200
`define PSD_RESTART_MS 2000
`define PSD_DISC_KOHM 150

`endif

// *** hdl/psd_pkg.sv ***
package psd_pkg;
  typedef enum logic [1:0] {
    PSD_PWR_7W = 2'b00,
    PSD_PWR_15W4 = 2'b01,
    PSD_PWR_30W = 2'b10
  } psd_power_type;

  typedef enum logic [1:0] {
    PSD_ST_RESET = 2'b00,
    PSD_ST_SAMPLE = 2'b01,
    PSD_ST_RUN = 2'b11
  } psd_state_type;
endpackage

// *** hdl/psd_band_cmp.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psd_consts.svh"
module psd_band_cmp
  import psd_pkg::*;
(
  input wire logic [`PSD_CODE_W-1:0] code,
  input wire logic [`PSD_CODE_W-1:0] threshold,
  output logic above
);
  // Boundary value belongs to the upper band
  assign above = (code >= threshold);
endmodule // psd_band_cmp
`default_nettype wire

// *** hdl/psd_mode_strap_decoder.sv ***
// How it works
// [RULE1] While reset is asserted the block is idle and the pass switch output is held off.
// [RULE2] On leaving reset the block samples the strap pin level once and derives all options from that sample.
// [RULE3] The sampled level is sorted into one of sixteen bands by fifteen voltage thresholds.
// [RULE4] Bands 0-7 are midspan and 8-15 endpoint; bands 0-3 and 8-11 restart after disconnection, others auto restart after 2 s.
// [RULE5] Band modulo four picks type, available power and classification/mark parts.
// [RULE6] After the sample the strap pin turns into the LED transistor drive output.
// [RULE7] The decoded mode stays fixed until the next reset.
// [RULE8] The digitized strap code is compared against the thresholds and latched into mode registers in one cycle.
// [RULE9] Placement sets the detection repeat interval: 400 ms endpoint, 2.2 s midspan.
// [RULE10] In restart-after-disconnection mode detection resumes only after port resistance exceeds 150 kohm.
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "psd_consts.svh"
module psd_mode_strap_decoder
  import psd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [`PSD_CODE_W-1:0] strap_code,
  input wire logic strap_code_valid,
  output logic strap_pin_out,
  output logic strap_pin_oe,
  input wire logic led_request,
  input wire logic fault_event,
  input wire logic port_open_event,
  input wire logic switch_request,
  output logic output_pass_switch,
  output logic endpoint_mode,
  output logic auto_restart,
  output logic pse_type2,
  output logic class_parts,
  output logic mark_parts,
  output logic [1:0] power_level,
  output logic [31:0] detect_interval_ms,
  output logic [31:0] restart_wait_ms,
  output logic detect_allowed,
  output logic mode_valid,
  input wire logic [`PSD_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int NTH = 15;
  localparam logic [`PSD_CODE_W*NTH-1:0] TH = {`PSD_TH_14, `PSD_TH_13, `PSD_TH_12,
    `PSD_TH_11, `PSD_TH_10, `PSD_TH_09, `PSD_TH_08, `PSD_TH_07, `PSD_TH_06,
    `PSD_TH_05, `PSD_TH_04, `PSD_TH_03, `PSD_TH_02, `PSD_TH_01, `PSD_TH_00};
  localparam logic [31:0] DET_ENDPT = 32'(`PSD_DET_ENDPT_MS);
  localparam logic [31:0] DET_MIDSP = 32'(`PSD_DET_MIDSP_MS);
  localparam logic [31:0] RESTART_MS = 32'(`PSD_RESTART_MS);

  psd_state_type state_q;
  logic [NTH-1:0] above;
  logic [3:0] band;
  logic [3:0] band_q;
  logic endpt_q, autors_q, type2_q, class_q, mark_q;
  logic [1:0] pwr_q;
  logic hold_det_q;
  logic sw_en_q;
  logic rd_pend_q;
  logic [31:0] rdata_q;
  logic [11:0] mode_word;

  genvar g;
  generate
    for (g = 0; g < NTH; g++) begin : g_cmp
      psd_band_cmp u_cmp (
        .code(strap_code),
        .threshold(TH[g*`PSD_CODE_W +: `PSD_CODE_W]),
        .above(above[g])
      ); // see [RULE3]
    end
  endgenerate

  // Thermometer to band index
  always_comb begin
    band = 4'h0;
    for (int i = 0; i < NTH; i++) begin
      if (above[i]) begin
        band = 4'(i + 1); // see [RULE3]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= PSD_ST_RESET; // see [RULE1]
    end else begin
      case (state_q)
        PSD_ST_RESET: state_q <= PSD_ST_SAMPLE;
        PSD_ST_SAMPLE: if (strap_code_valid) begin
          state_q <= PSD_ST_RUN; // see [RULE2]
        end
        PSD_ST_RUN: state_q <= PSD_ST_RUN; // see [RULE7]
        default: state_q <= PSD_ST_RESET;
      endcase
    end
  end

  // Single-cycle latch of the decoded band
  always_ff @(posedge clk) begin
    if (reset) begin
      band_q <= 4'h0;
      endpt_q <= 1'b0;
      autors_q <= 1'b0;
      type2_q <= 1'b0;
      class_q <= 1'b0;
      mark_q <= 1'b0;
      pwr_q <= PSD_PWR_7W;
    end else if (state_q == PSD_ST_SAMPLE && strap_code_valid) begin
      band_q <= band; // see [RULE8]
      endpt_q <= band[3]; // see [RULE4]
      autors_q <= band[2]; // see [RULE4]
      case (band[1:0]) // see [RULE5]
        2'b00: begin
          type2_q <= 1'b1;
          pwr_q <= PSD_PWR_30W;
          class_q <= 1'b0;
          mark_q <= 1'b0;
        end
        2'b01: begin
          type2_q <= 1'b0;
          pwr_q <= PSD_PWR_7W;
          class_q <= 1'b1;
          mark_q <= 1'b0;
        end
        2'b10: begin
          type2_q <= 1'b0;
          pwr_q <= PSD_PWR_15W4;
          class_q <= 1'b0;
          mark_q <= 1'b0;
        end
        default: begin
          type2_q <= 1'b1;
          pwr_q <= PSD_PWR_30W;
          class_q <= 1'b1;
          mark_q <= 1'b1;
        end
      endcase
    end
  end

  // Detection hold after fault in restart-after-disconnection mode; set wins
  always_ff @(posedge clk) begin
    if (reset) begin
      hold_det_q <= 1'b0;
    end else if (state_q == PSD_ST_RUN && fault_event && !autors_q) begin
      hold_det_q <= 1'b1; // see [RULE10]
    end else if (port_open_event) begin
      hold_det_q <= 1'b0; // see [RULE10]
    end
  end

  // Software switch enable
  always_ff @(posedge clk) begin
    if (reset) begin
      sw_en_q <= 1'b0;
    end else if (avs_write && avs_address == `PSD_REG_CTRL) begin
      sw_en_q <= avs_writedata[0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      output_pass_switch <= 1'b0; // see [RULE1]
    end else begin
      output_pass_switch <= (state_q == PSD_ST_RUN) && sw_en_q && switch_request;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      strap_pin_oe <= 1'b0;
      strap_pin_out <= 1'b0;
    end else begin
      strap_pin_oe <= (state_q == PSD_ST_RUN); // see [RULE6]
      strap_pin_out <= (state_q == PSD_ST_RUN) && led_request; // see [RULE6]
    end
  end

  assign mode_word = {(state_q == PSD_ST_RUN), pwr_q, mark_q, class_q, type2_q, autors_q, endpt_q, band_q};

  // Avalon slave: reads answered one cycle after request
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_pend_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      rd_pend_q <= avs_read && !rd_pend_q;
      if (avs_read && !rd_pend_q) begin
        case (avs_address)
          `PSD_REG_MODE: rdata_q <= {20'h0_0000, mode_word};
          `PSD_REG_CTRL: rdata_q <= {31'h0000_0000, sw_en_q};
          `PSD_REG_STAT: rdata_q <= {29'h0000_0000, hold_det_q, state_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_waitrequest = avs_read && !rd_pend_q;
  assign avs_readdata = rdata_q;

  assign endpoint_mode = endpt_q;
  assign auto_restart = autors_q;
  assign pse_type2 = type2_q;
  assign class_parts = class_q;
  assign mark_parts = mark_q;
  assign power_level = pwr_q;
  assign mode_valid = (state_q == PSD_ST_RUN);
  assign detect_interval_ms = endpt_q ? DET_ENDPT : DET_MIDSP; // see [RULE9]
  assign restart_wait_ms = RESTART_MS; // see [RULE4]
  assign detect_allowed = (state_q == PSD_ST_RUN) && !hold_det_q; // see [RULE10]
endmodule // psd_mode_strap_decoder
`default_nettype wire

// *** bench/psd_strap_net.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "psd_consts.svh"
module psd_strap_net (
  input wire logic [3:0] band,
  output logic [11:0] strap_code,
  output logic strap_code_valid
);
  logic [11:0] th [16];
  // Code sits exactly on the band's lower edge
  assign th = '{12'h000, `PSD_TH_00, `PSD_TH_01, `PSD_TH_02, `PSD_TH_03, `PSD_TH_04, `PSD_TH_05, `PSD_TH_06,
    `PSD_TH_07, `PSD_TH_08, `PSD_TH_09, `PSD_TH_10, `PSD_TH_11, `PSD_TH_12, `PSD_TH_13, `PSD_TH_14};
  assign strap_code = th[band];
  assign strap_code_valid = 1'b1;
endmodule // psd_strap_net
`default_nettype wire

// *** bench/psd_mode_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module psd_mode_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic output_pass_switch,
  input wire logic mode_valid,
  input wire logic strap_pin_oe,
  input wire logic strap_code_valid,
  input wire logic endpoint_mode,
  input wire logic auto_restart,
  input wire logic pse_type2,
  input wire logic [1:0] power_level,
  input wire logic [31:0] detect_interval_ms,
  input wire logic [31:0] restart_wait_ms
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_rst; disable iff (1'b0) reset |=> !output_pass_switch && !mode_valid && !strap_pin_oe; endproperty
  a_rst: assert property (p_rst) else $error("active in reset");
  property p_sw; output_pass_switch |-> mode_valid; endproperty
  a_sw: assert property (p_sw) else $error("switch before mode");
  property p_oe; strap_pin_oe |-> mode_valid; endproperty
  a_oe: assert property (p_oe) else $error("pin driven before sample");
  property p_hold; mode_valid |=> $stable({endpoint_mode, auto_restart, pse_type2, power_level}); endproperty
  a_hold: assert property (p_hold) else $error("mode changed");
  property p_det; mode_valid |-> detect_interval_ms == (endpoint_mode ? 32'h0000_0190 : 32'h0000_0898); endproperty
  a_det: assert property (p_det) else $error("detect interval");
  property p_rs; mode_valid && auto_restart |-> restart_wait_ms == 32'h0000_07D0; endproperty
  a_rs: assert property (p_rs) else $error("restart wait");
  property p_pwr; mode_valid |-> pse_type2 == (power_level == 2'h2); endproperty
  a_pwr: assert property (p_pwr) else $error("type and power");
  property p_lat; !mode_valid && strap_code_valid && !$past(reset) |=> mode_valid; endproperty
  a_lat: assert property (p_lat) else $error("latch late");
endmodule // psd_mode_sva
bind psd_mode_strap_decoder psd_mode_sva psd_mode_sva_i (.clk, .reset, .output_pass_switch, .mode_valid,
  .strap_pin_oe, .strap_code_valid, .endpoint_mode, .auto_restart, .pse_type2, .power_level,
  .detect_interval_ms, .restart_wait_ms);
`default_nettype wire

// *** bench/psd_mode_strap_decoder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("Error %s exp %0h got %0h", n, e, g); end end
module psd_mode_strap_decoder_tb;
  logic clk = 0, reset = 1, switch_request = 0, avs_read = 0, avs_write = 0;
  logic [3:0] avs_address = 4'h0, band = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, rd, avs_readdata, detect_interval_ms, restart_wait_ms;
  logic [11:0] strap_code, e;
  logic [1:0] power_level;
  logic strap_code_valid, strap_pin_oe, output_pass_switch, endpoint_mode, auto_restart, pse_type2;
  logic class_parts, mark_parts, mode_valid, avs_waitrequest, detect_allowed, strap_pin_out;
  logic led_request = 0, fault_event = 0, port_open_event = 0;
  int fail_count = 0, compares = 0;
  psd_strap_net psd_strap_net_i (.band, .strap_code, .strap_code_valid);
  psd_mode_strap_decoder psd_mode_strap_decoder_i (.clk, .reset, .strap_code, .strap_code_valid, .strap_pin_out,
    .strap_pin_oe, .led_request, .fault_event, .port_open_event, .switch_request,
    .output_pass_switch, .endpoint_mode, .auto_restart, .pse_type2, .class_parts, .mark_parts, .power_level,
    .detect_interval_ms, .restart_wait_ms, .detect_allowed, .mode_valid, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);
  initial forever #5 clk = ~clk;
  task do_reset(input int n);
    reset <= 1'b1;
    repeat (n) @(posedge clk);
    reset <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    n = 0;
    // Look mid-cycle: the value seen here is what the next rising edge samples
    @(negedge clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(negedge clk);
    end
    if (n == 20) begin
      fail_count++;
    end
    rd = avs_readdata;
    @(posedge clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task t_bands;
    for (int b = 0; b < 16; b++) begin
      band <= 4'(b);
      do_reset(3);
      e = {1'b1, (b % 4 == 1) ? 2'h0 : (b % 4 == 2) ? 2'h1 : 2'h2, b % 4 == 3, b % 2 == 1, b % 4 == 0 || b % 4 == 3,
        b % 8 > 3, b > 7, 4'(b)};
      bus(1'b0, 4'h0, 32'h0000_0000);
      `CHK("mode reg", {20'h0_0000, e}, rd)
      `CHK("mode", e[11:4], {mode_valid, power_level, mark_parts, class_parts, pse_type2, auto_restart, endpoint_mode})
      `CHK("interval", b > 7 ? 32'h0000_0190 : 32'h0000_0898, detect_interval_ms)
      `CHK("pin oe", 1'b1, strap_pin_oe)
    end
  endtask
  task t_hold;
    band <= 4'h5;
    do_reset(3);
    band <= 4'hC;
    repeat (10) @(posedge clk);
    `CHK("held", 1'b0, endpoint_mode)
    do_reset(3);
    `CHK("new mode", 1'b1, endpoint_mode)
  endtask
  task t_fault;
    band <= 4'h0;
    do_reset(3);
    led_request <= 1'b1;
    fault_event <= 1'b1;
    @(posedge clk);
    fault_event <= 1'b0;
    @(posedge clk);
    `CHK("det held", 1'b0, detect_allowed)
    `CHK("led", 1'b1, strap_pin_out)
    fault_event <= 1'b1;
    port_open_event <= 1'b1;
    @(posedge clk);
    fault_event <= 1'b0;
    @(posedge clk);
    `CHK("set wins", 1'b0, detect_allowed)
    @(posedge clk);
    port_open_event <= 1'b0;
    @(posedge clk);
    `CHK("det resumed", 1'b1, detect_allowed)
    led_request <= 1'b0;
    band <= 4'h4;
    do_reset(3);
    fault_event <= 1'b1;
    @(posedge clk);
    fault_event <= 1'b0;
    @(posedge clk);
    `CHK("auto no hold", 1'b1, detect_allowed)
    `CHK("led off", 1'b0, strap_pin_out)
  endtask
  task t_switch;
    switch_request <= 1'b1;
    bus(1'b1, 4'h4, 32'h0000_0001);
    bus(1'b0, 4'h4, 32'h0000_0000);
    `CHK("ctrl", 32'h0000_0001, rd)
    `CHK("switch on", 1'b1, output_pass_switch)
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("switch in reset", 1'b0, output_pass_switch)
    do_reset(1);
    `CHK("switch after reset", 1'b0, output_pass_switch)
    bus(1'b0, 4'hC, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rd)
  endtask
  task close_out;
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    close_out;
  end
  initial begin
    do_reset(20);
    t_bands;
    t_hold;
    t_fault;
    t_switch;
    close_out;
  end
endmodule // psd_mode_strap_decoder_tb
`default_nettype wire
